// ===== logic/depth_offset_calc.sv
// per-polygon depth offset calculator, two cycles from start to done
`timescale 1ns/1ps
module depth_offset_calc (
    input  wire logic clk,
    input  wire logic rst_n,
    offset_if.calc    ofs
);
    import raster_pkg::*;

    logic [SLOPE_W-1:0]         ax;
    logic [SLOPE_W-1:0]         ay;
    logic [SLOPE_W-1:0]         m_nxt;
    logic [SLOPE_W-1:0]         r_nxt;
    logic [SLOPE_W-1:0]         m_r;
    logic [SLOPE_W-1:0]         r_r;
    logic                       stage_r;
    logic signed [SLOPE_W+PARAM_W:0] pm;
    logic signed [SLOPE_W+PARAM_W:0] pr;
    logic signed [SLOPE_W+PARAM_W+1:0] sum;
    logic signed [OFS_W-1:0]    ofs_nxt;
    logic signed [OFS_W-1:0]    ofs_r;
    logic                       done_r;
    int                         sh;

    // =====================================================
    // slope and resolution
    always_comb begin
        sh = Z_FRAC + int'(ofs.zexp) - MANT_BITS;
        ax = ofs.dzdx[SLOPE_W-1] ? SLOPE_W'(-ofs.dzdx) : SLOPE_W'(ofs.dzdx);
        ay = ofs.dzdy[SLOPE_W-1] ? SLOPE_W'(-ofs.dzdy) : SLOPE_W'(ofs.dzdy);
        m_nxt = (ax > ay) ? ax : ay;
        if (!ofs.is_float) begin
            r_nxt = R_FIXED;
        end else if (sh <= 0) begin
            r_nxt = R_FLOOR;
        end else begin
            r_nxt = (sh < SLOPE_W) ? (R_FLOOR << sh[4:0]) : (R_FLOOR << (SLOPE_W-1));
        end
    end

    // first stage registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            m_r     <= '0;
            r_r     <= '0;
            stage_r <= 1'b0;
        end else begin
            stage_r <= ofs.start;
            if (ofs.start) begin
                m_r <= m_nxt;
                r_r <= r_nxt;
            end
        end
    end

    // o = m * factor + r * units, saturated
    always_comb begin
        pm  = ((SLOPE_W+PARAM_W+1)'($signed({1'b0, m_r})) * (SLOPE_W+PARAM_W+1)'(ofs.factor)) >>> FACTOR_FR;
        pr  = (SLOPE_W+PARAM_W+1)'($signed({1'b0, r_r})) * (SLOPE_W+PARAM_W+1)'(ofs.units);
        sum = (SLOPE_W+PARAM_W+2)'(pm) + (SLOPE_W+PARAM_W+2)'(pr);
        if (sum > (SLOPE_W+PARAM_W+2)'($signed(OFS_MAX))) begin
            ofs_nxt = OFS_MAX;
        end else if (sum < (SLOPE_W+PARAM_W+2)'($signed(OFS_MIN))) begin
            ofs_nxt = OFS_MIN;
        end else begin
            ofs_nxt = OFS_W'(sum);
        end
    end

    // second stage: one offset per polygon
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ofs_r  <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= stage_r;
            if (stage_r) begin
                ofs_r <= ofs_nxt;
            end
        end
    end

    assign ofs.offset = ofs_r;
    assign ofs.done   = done_r;
endmodule : depth_offset_calc

// ===== logic/offset_if.sv
// request and answer between the control stage and the offset calculator
`timescale 1ns/1ps
interface offset_if;
    import raster_pkg::*;
    logic                      start;
    logic signed [SLOPE_W-1:0] dzdx;
    logic signed [SLOPE_W-1:0] dzdy;
    logic signed [EXP_W-1:0]   zexp;
    logic                      is_float;
    logic signed [PARAM_W-1:0] factor;
    logic signed [PARAM_W-1:0] units;
    logic                      done;
    logic signed [OFS_W-1:0]   offset;
    modport ctrl (output start, dzdx, dzdy, zexp, is_float, factor, units, input done, offset);
    modport calc (input start, dzdx, dzdy, zexp, is_float, factor, units, output done, offset);
endinterface : offset_if

// ===== logic/polygon_raster_ctrl.sv
// polygon rasterization control: style, culling, depth offset, clamp, coverage
`timescale 1ns/1ps
// What this block does
// - style writes are taken only with the both-faces selector; apply to both faces
// - point style passes only vertex point fragments, no interior or edge ones
// - line style passes only fragments from the edge line rasterizer
// - fill passes area fragments; style is applied after culling, at polygon start
// - area antialias only in fill; point and line use their own antialias enables
// - one offset per polygon, added to every fragment when enabled for its style
// - offset is max slope times factor plus resolution times units, both signed
// - max slope approximated as larger absolute depth derivative
// - fixed depth buffer uses one constant minimum resolvable difference
// - float depth buffer resolution is two to the exponent minus mantissa bits
// - offsets of one resolution step stay distinct in fragment depth
// - fixed depth slope and offset work on depth normalized to zero..one
// - three separate offset enables for point, line and fill styles
// - fragment depth clamped to zero..one after offset addition
// - depth clamp applies also for a float depth buffer
// - multisample emits a fragment when at least one sample is covered
// - culled polygons under multisample produce no fragments
// - coverage bit is one exactly when its sample passes point sampling
// - per-sample data evaluated at sample location, sharing allowed
// - flat and perspective-free qualifiers pass unchanged under multisample
// - multisample polygon algorithm only in fill; others use point or line rules
// - reset gives smoothing off, fill style, zero factor and units, offsets off
// - front drawn if cull off or discard back; back if cull off or discard front
module polygon_raster_ctrl (
    input  wire logic                          SYS_CLK,
    input  wire logic                          RST_N,
    // state writes
    input  wire logic                          STYLE_WR,
    input  wire logic [1:0]                    STYLE_FACE,
    input  wire raster_pkg::raster_style_e     STYLE_VAL,
    output logic                               STYLE_REJECT,
    input  wire logic                          PARAM_WR,
    input  wire logic [raster_pkg::PARAM_W-1:0] FACTOR_IN,
    input  wire logic [raster_pkg::PARAM_W-1:0] UNITS_IN,
    input  wire logic                          ENABLE_WR,
    input  wire logic                          AREA_AA_IN,
    input  wire logic [2:0]                    OFFSET_EN_IN,
    // static controls
    input  wire logic                          FACE_CULL_ENABLE,
    input  wire raster_pkg::face_e             FACE_DISCARD_SELECT,
    input  wire logic                          POINT_AA_ENABLE,
    input  wire logic                          LINE_AA_ENABLE,
    input  wire logic                          MULTISAMPLE_ENABLE,
    input  wire logic                          SAMPLE_BUFFERS_ONE,
    input  wire logic                          DEPTH_IS_FLOAT,
    // current state view
    output raster_pkg::raster_style_e          RASTER_STYLE_SELECT,
    output logic                               AREA_ANTIALIAS_ENABLE,
    output logic [2:0]                         OFFSET_ENABLES,
    output logic [raster_pkg::PARAM_W-1:0]     FACTOR_OUT,
    output logic [raster_pkg::PARAM_W-1:0]     UNITS_OUT,
    // polygon header in
    input  wire logic                          POLY_VALID,
    output logic                               POLY_READY,
    input  wire logic                          POLY_FRONT,
    input  wire logic [raster_pkg::SLOPE_W-1:0] POLY_DZDX,
    input  wire logic [raster_pkg::SLOPE_W-1:0] POLY_DZDY,
    input  wire logic [raster_pkg::EXP_W-1:0]  POLY_ZEXP,
    // per-polygon routing to the sub-rasterizers
    output logic                               PATH_POINT,
    output logic                               PATH_LINE,
    output logic                               PATH_AREA,
    output logic                               PATH_AA,
    output logic                               PATH_MS,
    output logic                               POLY_CULLED,
    // fragment in
    input  wire logic                          FRAG_VALID,
    output logic                               FRAG_READY,
    input  wire raster_pkg::frag_src_e         FRAG_SRC,
    input  wire logic                          FRAG_LAST,
    input  wire logic [raster_pkg::XY_W-1:0]   FRAG_X,
    input  wire logic [raster_pkg::XY_W-1:0]   FRAG_Y,
    input  wire logic [raster_pkg::Z_W-1:0]    FRAG_Z,
    input  wire logic                          FRAG_CENTER_HIT,
    input  wire logic [raster_pkg::SAMPLES-1:0] FRAG_SAMPLE_HIT,
    input  wire logic [raster_pkg::QUAL_W-1:0] FRAG_QUAL,
    // fragment out
    output logic                               OUT_VALID,
    input  wire logic                          OUT_READY,
    output logic [raster_pkg::XY_W-1:0]        OUT_X,
    output logic [raster_pkg::XY_W-1:0]        OUT_Y,
    output logic [raster_pkg::Z_W-1:0]         OUT_Z,
    output logic [raster_pkg::SAMPLES-1:0]     OUT_COVERAGE,
    output logic [raster_pkg::QUAL_W-1:0]      OUT_QUAL,
    output logic                               OUT_SAMPLE_EVAL
);
    import raster_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_OFFSET = 3'b010,
        ST_STREAM = 3'b100
    } state_e;

    state_e                    state_r;
    raster_style_e             style_r;
    logic                      area_aa_r;
    logic [2:0]                ofs_en_r;
    logic [PARAM_W-1:0]        factor_r;
    logic [PARAM_W-1:0]        units_r;
    logic                      reject_r;
    // per-polygon latched state
    raster_style_e             poly_style_r;
    logic                      poly_culled_r;
    logic                      poly_aa_r;
    logic                      poly_ms_r;
    logic                      poly_ofs_en_r;
    logic [SLOPE_W-1:0]        dzdx_r;
    logic [SLOPE_W-1:0]        dzdy_r;
    logic [EXP_W-1:0]          zexp_r;
    logic signed [OFS_W-1:0]   poly_ofs_r;
    logic                      start_r;
    // fragment path
    logic                      poly_take;
    logic                      frag_take;
    logic                      src_ok;
    logic                      hit_ok;
    logic                      keep;
    logic [SAMPLES-1:0]        cov_nxt;
    logic signed [OFS_W:0]     zsum;
    logic [Z_W-1:0]            z_nxt;
    logic                      culled_nxt;
    logic                      ms_nxt;
    logic                      aa_nxt;
    logic                      en_nxt;
    logic                      out_valid_r;
    logic [XY_W-1:0]           out_x_r;
    logic [XY_W-1:0]           out_y_r;
    logic [Z_W-1:0]            out_z_r;
    logic [SAMPLES-1:0]        out_cov_r;
    logic [QUAL_W-1:0]         out_qual_r;
    logic                      out_seval_r;

    offset_if ofs ();

    // =====================================================
    // offset calculator
    depth_offset_calc u_calc (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .ofs   (ofs.calc)
    );

    assign ofs.start    = start_r;
    assign ofs.dzdx     = $signed(dzdx_r);
    assign ofs.dzdy     = $signed(dzdy_r);
    assign ofs.zexp     = $signed(zexp_r);
    assign ofs.is_float = DEPTH_IS_FLOAT;
    assign ofs.factor   = $signed(factor_r);
    assign ofs.units    = $signed(units_r);

    // =====================================================
    // style state: only the both-faces selector is accepted
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            style_r  <= STYLE_FILL;
            reject_r <= 1'b0;
        end else begin
            reject_r <= STYLE_WR && (STYLE_FACE != FACE_BOTH);
            if (STYLE_WR && STYLE_FACE == FACE_BOTH) begin
                style_r <= STYLE_VAL;
            end
        end
    end

    // offset parameters
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            factor_r <= PARAM_INIT;
            units_r  <= PARAM_INIT;
        end else if (PARAM_WR) begin
            factor_r <= FACTOR_IN;
            units_r  <= UNITS_IN;
        end
    end

    // antialias and offset enables
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            area_aa_r <= 1'b0;
            ofs_en_r  <= 3'h0;
        end else if (ENABLE_WR) begin
            area_aa_r <= AREA_AA_IN;
            ofs_en_r  <= OFFSET_EN_IN;
        end
    end

    // =====================================================
    // per-polygon decisions taken from the header
    always_comb begin
        unique case (FACE_DISCARD_SELECT)
            FACE_FRONT: culled_nxt = FACE_CULL_ENABLE && POLY_FRONT;
            FACE_BACK:  culled_nxt = FACE_CULL_ENABLE && !POLY_FRONT;
            default:    culled_nxt = FACE_CULL_ENABLE;
        endcase
        unique case (style_r)
            STYLE_POINT: begin
                aa_nxt = POINT_AA_ENABLE;
                en_nxt = ofs_en_r[0];
            end
            STYLE_LINE: begin
                aa_nxt = LINE_AA_ENABLE;
                en_nxt = ofs_en_r[1];
            end
            default: begin
                aa_nxt = area_aa_r;
                en_nxt = ofs_en_r[2];
            end
        endcase
        ms_nxt = MULTISAMPLE_ENABLE && SAMPLE_BUFFERS_ONE && (style_r == STYLE_FILL);
    end

    assign poly_take = POLY_VALID && (state_r == ST_IDLE);

    // latch polygon state once culling is known
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            poly_style_r  <= STYLE_FILL;
            poly_culled_r <= 1'b0;
            poly_aa_r     <= 1'b0;
            poly_ms_r     <= 1'b0;
            poly_ofs_en_r <= 1'b0;
            dzdx_r        <= '0;
            dzdy_r        <= '0;
            zexp_r        <= '0;
        end else if (poly_take) begin
            poly_style_r  <= style_r;
            poly_culled_r <= culled_nxt;
            poly_aa_r     <= aa_nxt;
            poly_ms_r     <= ms_nxt;
            poly_ofs_en_r <= en_nxt;
            dzdx_r        <= POLY_DZDX;
            dzdy_r        <= POLY_DZDY;
            zexp_r        <= POLY_ZEXP;
        end
    end

    // =====================================================
    // polygon sequencing
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
            start_r <= 1'b0;
        end else begin
            start_r <= poly_take;
            unique case (state_r)
                ST_IDLE: begin
                    if (poly_take) begin
                        state_r <= ST_OFFSET;
                    end
                end
                ST_OFFSET: begin
                    if (ofs.done) begin
                        state_r <= ST_STREAM;
                    end
                end
                ST_STREAM: begin
                    if (frag_take && FRAG_LAST) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // offset held for the whole polygon
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            poly_ofs_r <= '0;
        end else if (ofs.done) begin
            poly_ofs_r <= poly_ofs_en_r ? ofs.offset : $signed(OFS_ZERO);
        end
    end

    // =====================================================
    // fragment filtering, offset and clamp
    assign frag_take = FRAG_VALID && FRAG_READY;

    always_comb begin
        unique case (poly_style_r)
            STYLE_POINT: src_ok = (FRAG_SRC == SRC_POINT);
            STYLE_LINE:  src_ok = (FRAG_SRC == SRC_LINE);
            default:     src_ok = (FRAG_SRC == SRC_AREA);
        endcase
        if (poly_ms_r) begin
            cov_nxt = FRAG_SAMPLE_HIT;
            hit_ok  = (FRAG_SAMPLE_HIT != COV_NONE);
        end else begin
            cov_nxt = FRAG_CENTER_HIT ? COV_FULL : COV_NONE;
            hit_ok  = FRAG_CENTER_HIT;
        end
        keep = src_ok && hit_ok && !poly_culled_r;
        zsum = (OFS_W+1)'($signed({1'b0, FRAG_Z})) + (OFS_W+1)'(poly_ofs_r);
        if (zsum < 0) begin
            z_nxt = '0;
        end else if (zsum > (OFS_W+1)'($signed({1'b0, Z_ONE}))) begin
            z_nxt = Z_ONE;
        end else begin
            z_nxt = Z_W'(zsum);
        end
    end

    // output stage: one fragment register with ready pass-back
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            out_valid_r <= 1'b0;
        end else if (frag_take) begin
            out_valid_r <= keep;
        end else if (OUT_READY) begin
            out_valid_r <= 1'b0;
        end
    end

    // fragment data
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            out_x_r     <= '0;
            out_y_r     <= '0;
            out_z_r     <= '0;
            out_cov_r   <= '0;
            out_qual_r  <= '0;
            out_seval_r <= 1'b0;
        end else if (frag_take && keep) begin
            out_x_r     <= FRAG_X;
            out_y_r     <= FRAG_Y;
            out_z_r     <= z_nxt;
            out_cov_r   <= cov_nxt;
            out_qual_r  <= FRAG_QUAL;
            out_seval_r <= poly_ms_r;
        end
    end

    // =====================================================
    // outputs
    assign FRAG_READY            = (state_r == ST_STREAM) && (!out_valid_r || OUT_READY);
    assign POLY_READY            = (state_r == ST_IDLE);
    assign STYLE_REJECT          = reject_r;
    assign RASTER_STYLE_SELECT   = style_r;
    assign AREA_ANTIALIAS_ENABLE = area_aa_r;
    assign OFFSET_ENABLES        = ofs_en_r;
    assign FACTOR_OUT            = factor_r;
    assign UNITS_OUT             = units_r;
    assign PATH_POINT            = (poly_style_r == STYLE_POINT);
    assign PATH_LINE             = (poly_style_r == STYLE_LINE);
    assign PATH_AREA             = (poly_style_r == STYLE_FILL);
    assign PATH_AA               = poly_aa_r;
    assign PATH_MS               = poly_ms_r;
    assign POLY_CULLED           = poly_culled_r;
    assign OUT_VALID             = out_valid_r;
    assign OUT_X                 = out_x_r;
    assign OUT_Y                 = out_y_r;
    assign OUT_Z                 = out_z_r;
    assign OUT_COVERAGE          = out_cov_r;
    assign OUT_QUAL              = out_qual_r;
    assign OUT_SAMPLE_EVAL       = out_seval_r;
endmodule : polygon_raster_ctrl

// ===== logic/raster_pkg.sv
// shared constants and types for the polygon raster control stage
package raster_pkg;
    // =====================================================
    // datapath widths
    localparam int XY_W      = 12;   // window x and y
    localparam int Z_W       = 25;   // unsigned depth, 1.0 = 2^Z_FRAC
    localparam int Z_FRAC    = 24;
    localparam int SLOPE_W   = 26;   // signed depth slope, Z_FRAC fraction bits
    localparam int PARAM_W   = 16;   // signed factor and units
    localparam int FACTOR_FR = 8;    // fraction bits of the slope factor
    localparam int OFS_W     = 32;   // signed offset, Z_FRAC fraction bits
    localparam int EXP_W     = 6;    // signed max exponent of a float depth range
    localparam int MANT_BITS = 23;   // mantissa bits of a float depth buffer
    localparam int SAMPLES   = 4;    // coverage bits per pixel
    localparam int QUAL_W    = 2;    // interpolation qualifier flags
    // =====================================================
    // constants
    localparam logic [Z_W-1:0]     Z_ONE      = 25'h1000000;
    localparam logic [SLOPE_W-1:0] R_FIXED    = 26'h0000001;
    localparam logic [SLOPE_W-1:0] R_FLOOR    = 26'h0000001;
    localparam logic [PARAM_W-1:0] PARAM_INIT = 16'h0000;
    localparam logic [OFS_W-1:0]   OFS_MAX    = 32'h7fffffff;
    localparam logic [OFS_W-1:0]   OFS_MIN    = 32'h80000000;
    localparam logic [OFS_W-1:0]   OFS_ZERO   = 32'h00000000;
    localparam logic [SAMPLES-1:0] COV_FULL   = 4'hf;
    localparam logic [SAMPLES-1:0] COV_NONE   = 4'h0;
    // =====================================================
    // encodings
    typedef enum logic [1:0] {STYLE_POINT = 2'h0, STYLE_LINE = 2'h1, STYLE_FILL = 2'h2} raster_style_e;
    typedef enum logic [1:0] {FACE_FRONT = 2'h0, FACE_BACK = 2'h1, FACE_BOTH = 2'h2} face_e;
    // source tag of an incoming fragment
    typedef enum logic [1:0] {SRC_POINT = 2'h0, SRC_LINE = 2'h1, SRC_AREA = 2'h2} frag_src_e;
endpackage : raster_pkg

// ===== verification/polygon_raster_ctrl_sva.sv
// assertions on the polygon raster control ports
`timescale 1ns/1ps
module polygon_raster_ctrl_sva
    import raster_pkg::*;
(
    input wire logic SYS_CLK, RST_N, STYLE_WR, STYLE_REJECT, POLY_VALID, POLY_READY, POLY_FRONT, PATH_POINT,
    input wire logic PATH_LINE, PATH_AREA, PATH_AA, PATH_MS, POLY_CULLED, FACE_CULL_ENABLE, AREA_ANTIALIAS_ENABLE,
    input wire logic POINT_AA_ENABLE, LINE_AA_ENABLE, MULTISAMPLE_ENABLE, SAMPLE_BUFFERS_ONE, OUT_VALID,
    input wire logic OUT_SAMPLE_EVAL,
    input wire logic [1:0] STYLE_FACE,
    input wire raster_style_e STYLE_VAL, RASTER_STYLE_SELECT,
    input wire face_e FACE_DISCARD_SELECT,
    input wire logic [Z_W-1:0] OUT_Z,
    input wire logic [SAMPLES-1:0] OUT_COVERAGE
);
    // ==========
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence hdr_s;
        POLY_VALID && POLY_READY;
    endsequence
    AST_REJECT: assert property (STYLE_WR && STYLE_FACE != 2'h2 |=> STYLE_REJECT && $stable(RASTER_STYLE_SELECT))
        else $error("style write not refused");
    AST_STYLE: assert property (STYLE_WR && STYLE_FACE == 2'h2 |=> RASTER_STYLE_SELECT == $past(STYLE_VAL))
        else $error("style write lost");
    AST_PATH: assert property (hdr_s |=> PATH_AREA == ($past(RASTER_STYLE_SELECT) == STYLE_FILL))
        else $error("wrong path");
    AST_AA: assert property (hdr_s |=> PATH_AA == (PATH_AREA ? $past(AREA_ANTIALIAS_ENABLE) :
        PATH_LINE ? $past(LINE_AA_ENABLE) : $past(POINT_AA_ENABLE))) else $error("wrong antialias");
    AST_MS: assert property (hdr_s |=> PATH_MS == ($past(MULTISAMPLE_ENABLE) && $past(SAMPLE_BUFFERS_ONE) && PATH_AREA))
        else $error("wrong multisample");
    AST_CULL: assert property (hdr_s |=> POLY_CULLED == ($past(FACE_CULL_ENABLE) &&
        ($past(FACE_DISCARD_SELECT) == FACE_BOTH || $past(FACE_DISCARD_SELECT) == ($past(POLY_FRONT) ? FACE_FRONT : FACE_BACK))))
        else $error("wrong cull");
    AST_CLAMP: assert property (OUT_VALID |-> OUT_Z <= Z_ONE)
        else $error("depth above one");
    AST_COV: assert property (OUT_VALID |-> OUT_COVERAGE != COV_NONE && (OUT_SAMPLE_EVAL || OUT_COVERAGE == COV_FULL))
        else $error("wrong coverage");
endmodule : polygon_raster_ctrl_sva
bind polygon_raster_ctrl polygon_raster_ctrl_sva sva_i (.*);

// ===== verification/polygon_raster_ctrl_tb_top.sv
// self-checking bench for the polygon raster control stage
`timescale 1ns/1ps
module polygon_raster_ctrl_tb_top;
    import raster_pkg::*;
    logic SYS_CLK = 0, RST_N = 0, STYLE_WR = 0, PARAM_WR = 0, ENABLE_WR = 0, AREA_AA_IN = 0, POLY_VALID = 0, stall = 0;
    logic FACE_CULL_ENABLE = 0, POINT_AA_ENABLE = 1, LINE_AA_ENABLE = 0, MULTISAMPLE_ENABLE = 0, SAMPLE_BUFFERS_ONE = 1;
    logic DEPTH_IS_FLOAT = 0, POLY_FRONT = 1, FRAG_VALID = 0, FRAG_LAST = 0, FRAG_CENTER_HIT = 0, STYLE_REJECT, POLY_READY;
    logic PATH_POINT, PATH_LINE, PATH_AREA, PATH_AA, PATH_MS, POLY_CULLED, FRAG_READY, OUT_VALID, OUT_READY;
    logic OUT_SAMPLE_EVAL, AREA_ANTIALIAS_ENABLE;
    logic [1:0] STYLE_FACE = 0;
    raster_style_e STYLE_VAL = STYLE_FILL, RASTER_STYLE_SELECT, cur = STYLE_FILL;
    face_e FACE_DISCARD_SELECT = FACE_BACK;
    frag_src_e FRAG_SRC = SRC_AREA;
    logic [PARAM_W-1:0] FACTOR_IN = 0, UNITS_IN = 0, FACTOR_OUT, UNITS_OUT;
    logic [2:0] OFFSET_EN_IN = 0, OFFSET_ENABLES;
    logic [SLOPE_W-1:0] POLY_DZDX = 0, POLY_DZDY = 0;
    logic [EXP_W-1:0] POLY_ZEXP = 0;
    logic [XY_W-1:0] FRAG_X = 0, FRAG_Y = 0, OUT_X, OUT_Y;
    logic [Z_W-1:0] FRAG_Z = 0, OUT_Z;
    logic [SAMPLES-1:0] FRAG_SAMPLE_HIT = 0, OUT_COVERAGE;
    logic [QUAL_W-1:0] FRAG_QUAL = 0, OUT_QUAL;
    int miscompares = 0, check_count = 0, n;
    polygon_raster_ctrl DUT (.*);
    raster_sink sink (.clk(SYS_CLK), .stall(stall), .ready(OUT_READY));
    initial forever #25 SYS_CLK = ~SYS_CLK;
    // compare and count
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // bounded wait ran out
    task lim;
        if (n >= 20) begin
            miscompares++;
            wrap_up();
        end
    endtask : lim
    // style, parameter and enable writes in one cycle
    task cfg(input logic [1:0] f, input raster_style_e s, input logic [15:0] fa, un, input logic [2:0] en);
        {STYLE_WR, PARAM_WR, ENABLE_WR} <= 3'h7;
        STYLE_VAL <= s;
        {STYLE_FACE, FACTOR_IN, UNITS_IN, OFFSET_EN_IN, AREA_AA_IN} <= {f, fa, un, en, en[2]};
        @(posedge SYS_CLK);
        {STYLE_WR, PARAM_WR, ENABLE_WR} <= 3'h0;
        @(posedge SYS_CLK);
        if (f == 2'h2) cur = s;
        chk(STYLE_REJECT, f != 2'h2);
        chk(RASTER_STYLE_SELECT, cur);
        chk({FACTOR_OUT, UNITS_OUT}, {fa, un});
        chk({OFFSET_ENABLES, AREA_ANTIALIAS_ENABLE}, {en, en[2]});
    endtask : cfg
    // polygon header, then cull and path check
    task poly(input logic fr, input logic [SLOPE_W-1:0] dx, dy, input logic cul);
        POLY_VALID <= 1'b1;
        {POLY_FRONT, POLY_DZDX, POLY_DZDY} <= {fr, dx, dy};
        n = 0;
        do @(posedge SYS_CLK); while (!POLY_READY && ++n < 20);
        lim();
        POLY_VALID <= 1'b0;
        @(posedge SYS_CLK);
        chk(POLY_CULLED, cul);
        chk({PATH_POINT, PATH_LINE, PATH_AREA}, {cur == STYLE_POINT, cur == STYLE_LINE, cur == STYLE_FILL});
    endtask : poly
    // one fragment; k says it must come out with depth ez and coverage ec
    task frag(input frag_src_e src, input logic [Z_W-1:0] z, input logic c, last, k, input logic [3:0] sh,
              input logic [Z_W-1:0] ez, input logic [3:0] ec);
        FRAG_VALID <= 1'b1;
        {FRAG_SRC, FRAG_Y} <= {src, ~z[11:0]};
        {FRAG_Z, FRAG_X, FRAG_QUAL, FRAG_CENTER_HIT, FRAG_LAST, FRAG_SAMPLE_HIT} <= {z, z[11:0], z[1:0], c, last, sh};
        n = 0;
        do @(posedge SYS_CLK); while (!FRAG_READY && ++n < 20);
        lim();
        FRAG_VALID <= 1'b0;
        n = 0;
        do @(posedge SYS_CLK); while (k && !(OUT_VALID && OUT_READY) && ++n < 20);
        lim();
        chk(OUT_VALID, k);
        if (k) chk({OUT_Z, OUT_COVERAGE, OUT_QUAL, OUT_X, OUT_Y}, {ez, ec, z[1:0], z[11:0], ~z[11:0]});
    endtask : frag
    // verdict and end of run
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (5) @(posedge SYS_CLK);
        chk({RASTER_STYLE_SELECT, AREA_ANTIALIAS_ENABLE, OFFSET_ENABLES, FACTOR_OUT, UNITS_OUT}, {STYLE_FILL, 36'h0});
        chk(RASTER_STYLE_SELECT, STYLE_FILL);
        RST_N <= 1'b1;
        stall <= 1'b1;
        @(posedge SYS_CLK);
        cfg(2'h0, STYLE_POINT, 16'h0100, 16'h0002, 3'h4);
        poly(1'b1, 26'h3ffffe0, 26'h0000010, 1'b0);
        frag(SRC_AREA, 25'h100, 1'b1, 1'b0, 1'b1, 4'h0, 25'h122, 4'hf);
        frag(SRC_POINT, 25'h100, 1'b1, 1'b0, 1'b0, 4'h0, 25'h0, 4'h0);
        frag(SRC_AREA, 25'h200, 1'b0, 1'b0, 1'b0, 4'h0, 25'h0, 4'h0);
        frag(SRC_AREA, 25'hfffff0, 1'b1, 1'b1, 1'b1, 4'h0, Z_ONE, 4'hf);
        cfg(2'h2, STYLE_LINE, 16'h0000, 16'hffc0, 3'h4);
        poly(1'b0, 26'h0, 26'h0, 1'b0);
        frag(SRC_LINE, 25'h30, 1'b1, 1'b0, 1'b1, 4'h0, 25'h30, 4'hf);
        frag(SRC_AREA, 25'h30, 1'b1, 1'b1, 1'b0, 4'h0, 25'h0, 4'h0);
        cfg(2'h2, STYLE_FILL, 16'h0000, 16'hffc0, 3'h4);
        poly(1'b1, 26'h0, 26'h0, 1'b0);
        frag(SRC_AREA, 25'h30, 1'b1, 1'b1, 1'b1, 4'h0, 25'h0, 4'hf);
        {DEPTH_IS_FLOAT, POLY_ZEXP} <= {1'b1, 6'h03};
        cfg(2'h2, STYLE_FILL, 16'h0000, 16'h0001, 3'h4);
        poly(1'b1, 26'h0, 26'h0, 1'b0);
        frag(SRC_AREA, 25'h100, 1'b1, 1'b1, 1'b1, 4'h0, 25'h110, 4'hf);
        {DEPTH_IS_FLOAT, MULTISAMPLE_ENABLE, FACE_CULL_ENABLE} <= 3'h3;
        poly(1'b1, 26'h0, 26'h0, 1'b0);
        frag(SRC_AREA, 25'h40, 1'b0, 1'b1, 1'b1, 4'h5, 25'h41, 4'h5);
        poly(1'b0, 26'h0, 26'h0, 1'b1);
        frag(SRC_AREA, 25'h40, 1'b1, 1'b1, 1'b0, 4'hf, 25'h0, 4'h0);
        cfg(2'h2, STYLE_POINT, 16'h0000, 16'h0001, 3'h1);
        poly(1'b1, 26'h0, 26'h0, 1'b0);
        frag(SRC_POINT, 25'h50, 1'b1, 1'b1, 1'b1, 4'h0, 25'h51, 4'hf);
        wrap_up();
    end
endmodule : polygon_raster_ctrl_tb_top

// ===== verification/raster_sink.sv
// downstream fragment sink model with optional back-pressure
`timescale 1ns/1ps
module raster_sink (
    input  wire logic clk,
    input  wire logic stall,
    output logic      ready
);
    // ready toggles while stalling, else stays high
    always_ff @(posedge clk) begin
        ready <= stall ? !ready : 1'b1;
    end
endmodule : raster_sink
